// ==== core/ssp_port.sv ====
// Serial peripheral port, SPI master and slave, with Avalon-MM registers
// Assumes pins arrive asynchronous; the pad ring resolves the tri-state wires
// Function
// - Enable hands pins to the port
// - Master write to buffer starts transfer
// - Receive-only master still loads bytes
// - Bytes shift most significant bit first
// - Edge select set gives early data
// - Shift on one edge, sample opposite; a master sampling at end samples on the shift edge
// - Slave shifts on external clock, flags last
// - Slave byte flags and wakes after eight
// - Select control gates slave on low select
// - Select high floats data output once the synchronised select reaches it
// - Select high or disable clears bit count
// - Data output as input stops transmission
// - Sleep freezes master transfer in place
// - Enabled interrupt wakes processor after transfer
// - Reset disables port, aborts transfer
// - Standard modes map to polarity and edge
// - Mode field selects master rate or slave
// - Sample phase picks middle or end for a master with edge select set
// - Busy buffer write ignored, collision flagged
// - Byte to buffer sets full; overflow drops
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module ssp_port (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic sleep_in,
    input wire logic irq_en_in,
    input wire logic timer_two_in,
    input wire logic sck_in,
    input wire logic sdi_in,
    input wire logic ss_b_in,
    output logic sck_out,
    output logic sck_oe_out,
    output logic sdo_out,
    output logic sdo_oe_out,
    output logic port_interrupt_flag_out,
    output logic wake_out
);
    ssp_pkg::ssp_regs_t q;
    ssp_pkg::ssp_regs_t d;
    logic en;
    logic master;
    logic slave;
    logic ss_ctl;
    logic clock_idle_polarity;
    logic cke;
    logic sample_phase;
    logic sel_ok;
    logic acc;
    logic wr;
    logic rd;
    logic ld;
    logic tick;
    logic sck_rise;
    logic sck_fall;
    logic sl_lead;
    logic sl_trail;
    logic done;
    logic [5:0] half;

    assign en = q.con[ssp_pkg::CON_EN];
    assign master = en && (q.con[3:0] <= ssp_pkg::MODE_MT2);
    assign slave = en && (q.con[3:0] == ssp_pkg::MODE_S_SS
                          || q.con[3:0] == ssp_pkg::MODE_S_NOSS);
    assign ss_ctl = slave && q.con[3:0] == ssp_pkg::MODE_S_SS;
    assign clock_idle_polarity = q.con[ssp_pkg::CON_CKP];
    assign cke = q.stat[ssp_pkg::STAT_CKE - 6];
    assign sample_phase = q.stat[ssp_pkg::STAT_SMP - 6];
    assign sel_ok = !ss_ctl || !q.ss_s[1];
    // First cycle fetches read data; effects land when waitrequest is low
    assign acc = (avs_read_in || avs_write_in) && !q.rvalid;
    assign ld = avs_read_in && acc;
    assign wr = avs_write_in && q.rvalid && avs_byteenable_in[0];
    assign rd = avs_read_in && q.rvalid;
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !q.rvalid;
    assign avs_readdata_out = q.rdata;
    // Leading edge is the idle-to-active transition of the line
    assign sck_rise = q.sck_s[1] && !q.sck_p;
    assign sck_fall = !q.sck_s[1] && q.sck_p;
    assign sl_lead = clock_idle_polarity ? sck_fall : sck_rise;
    assign sl_trail = clock_idle_polarity ? sck_rise : sck_fall;

    always_comb begin
        unique case (q.con[3:0])
            ssp_pkg::MODE_M4: half = ssp_pkg::HALF_M4;
            ssp_pkg::MODE_M16: half = ssp_pkg::HALF_M16;
            default: half = ssp_pkg::HALF_M64;
        endcase
    end

    always_comb begin
        d = q;
        done = 1'b0;
        d.rvalid = acc;
        d.sck_s = {q.sck_s[0], sck_in};
        d.sdi_s = {q.sdi_s[0], sdi_in};
        d.ss_s = {q.ss_s[0], ss_b_in};
        d.t2_s = {q.t2_s[0], timer_two_in};
        d.sck_p = q.sck_s[1];
        d.t2_p = q.t2_s[1];
        tick = 1'b0;
        if (!sleep_in) begin
            // Timer mode toggles the line on each timer pulse: half its rate
            if (q.con[3:0] == ssp_pkg::MODE_MT2) begin
                tick = q.t2_s[1] && !q.t2_p;
            end else if (q.div == half) begin
                tick = 1'b1;
            end
        end
        if (q.st == ssp_pkg::ST_IDLE || tick) begin
            d.div = 6'h00;
        end else if (!sleep_in) begin
            d.div = q.div + 6'h01;
        end
        if (master) begin
            d.pin.sck_oe = 1'b1;
            d.pin.sdo_oe = !q.sdo_in;
            if (tick) begin
                unique case (q.st)
                    ssp_pkg::ST_LEAD: begin
                        d.pin.sck = !clock_idle_polarity;
                        d.st = ssp_pkg::ST_TRAIL;
                        if (cke && !sample_phase) begin
                            d.samp = q.sdi_s[1];
                        end else if (!cke) begin
                            d.pin.sdo = q.sr[7];
                        end
                    end
                    ssp_pkg::ST_TRAIL: begin
                        d.pin.sck = clock_idle_polarity;
                        // Pin sync lags two cycles: mid sampling needs the slower rates
                        if (cke && !sample_phase) begin
                            d.sr = {q.sr[6:0], q.samp};
                        end else begin
                            d.sr = {q.sr[6:0], q.sdi_s[1]};
                        end
                        if (cke) begin
                            d.pin.sdo = d.sr[7];
                        end
                        d.cnt = q.cnt + 3'h1;
                        done = q.cnt == ssp_pkg::BIT_LAST;
                        d.st = done ? ssp_pkg::ST_IDLE : ssp_pkg::ST_LEAD;
                    end
                    default: d.st = q.st;
                endcase
            end
        end else if (slave) begin
            d.pin.sck_oe = 1'b0;
            d.pin.sck = clock_idle_polarity;
            d.pin.sdo_oe = sel_ok && !q.sdo_in;
            if (ss_ctl && q.ss_s[1]) begin
                d.cnt = 3'h0;
                d.st = ssp_pkg::ST_IDLE;
            end else begin
                // Sample edge shifts in; the other edge presents the next bit
                if (cke ? sl_lead : sl_trail) begin
                    d.sr = {q.sr[6:0], q.sdi_s[1]};
                    d.cnt = q.cnt + 3'h1;
                    done = q.cnt == ssp_pkg::BIT_LAST;
                end
                if (cke ? sl_trail : sl_lead) begin
                    d.pin.sdo = q.sr[7];
                end
                d.st = (d.cnt == 3'h0) ? ssp_pkg::ST_IDLE : ssp_pkg::ST_LEAD;
            end
        end else begin
            d.pin.sck_oe = 1'b0;
            d.pin.sdo_oe = 1'b0;
            d.pin.sck = clock_idle_polarity;
            d.cnt = 3'h0;
            d.st = ssp_pkg::ST_IDLE;
        end
        if (done) begin
            d.flag = 1'b1;
            if (slave && q.bf) begin
                d.con[ssp_pkg::CON_OV] = 1'b1;
            end else begin
                d.buf_r = d.sr;
                d.bf = 1'b1;
            end
        end
        if (ld) begin
            unique case (avs_address_in)
                ssp_pkg::ADDR_BUF: d.rdata = {24'h00_0000, q.buf_r};
                ssp_pkg::ADDR_CON: d.rdata = {24'h00_0000, q.con};
                ssp_pkg::ADDR_STAT: d.rdata = {24'h00_0000, q.stat, 5'h00, q.bf};
                ssp_pkg::ADDR_PIN: d.rdata = {30'h0000_0000, q.flag, q.sdo_in};
                default: d.rdata = ssp_pkg::RD_ZERO;
            endcase
        end
        // A byte landing in the same cycle keeps the full flag set
        if (rd && avs_address_in == ssp_pkg::ADDR_BUF && !done) begin
            d.bf = 1'b0;
        end
        if (wr) begin
            unique case (avs_address_in)
                ssp_pkg::ADDR_BUF: begin
                    if (q.st != ssp_pkg::ST_IDLE || q.cnt != 3'h0) begin
                        d.con[ssp_pkg::CON_WRITE_COLLISION_FLAG] = 1'b1;
                    end else if (en) begin
                        d.buf_r = avs_writedata_in[7:0];
                        d.sr = avs_writedata_in[7:0];
                        d.pin.sdo = avs_writedata_in[7];
                        if (master) begin
                            d.st = ssp_pkg::ST_LEAD;
                        end
                    end
                end
                ssp_pkg::ADDR_CON: begin
                    // Sticky flags: writes only clear; a hardware set in this cycle survives if the flag was clear
                    d.con[5:0] = avs_writedata_in[5:0];
                    d.con[7] = avs_writedata_in[7] && q.con[7] || d.con[7] && !q.con[7];
                    d.con[6] = avs_writedata_in[6] && q.con[6] || d.con[6] && !q.con[6];
                end
                ssp_pkg::ADDR_STAT: d.stat = avs_writedata_in[7:6];
                ssp_pkg::ADDR_PIN: begin
                    d.sdo_in = avs_writedata_in[ssp_pkg::PIN_SDO_IN];
                    if (!avs_writedata_in[1] && !done) begin
                        d.flag = 1'b0;
                    end
                end
                default: d.sdo_in = q.sdo_in;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= '0;
            q.con <= ssp_pkg::CON_RESET;
            q.stat <= ssp_pkg::STAT_RESET;
            q.st <= ssp_pkg::ST_IDLE;
        end else begin
            q <= d;
        end
    end

    assign sck_out = q.pin.sck;
    assign sck_oe_out = q.pin.sck_oe;
    assign sdo_out = q.pin.sdo;
    assign sdo_oe_out = q.pin.sdo_oe;
    assign port_interrupt_flag_out = q.flag;
    assign wake_out = q.flag && irq_en_in;
endmodule

// ==== core/ssp_pkg.sv ====
// Constants, register map and state carriers for the serial port block
// Assumes a 32-bit Avalon-MM slave and a 50 MHz system clock
package ssp_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam logic [3:0] ADDR_BUF = 4'h0;
    localparam logic [3:0] ADDR_CON = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    localparam logic [3:0] ADDR_PIN = 4'hc;
    localparam logic [3:0] MODE_M4 = 4'h0;
    localparam logic [3:0] MODE_M16 = 4'h1;
    localparam logic [3:0] MODE_M64 = 4'h2;
    localparam logic [3:0] MODE_MT2 = 4'h3;
    localparam logic [3:0] MODE_S_SS = 4'h4;
    localparam logic [3:0] MODE_S_NOSS = 4'h5;
    // Half periods of the serial clock in system cycles, less one
    localparam logic [5:0] HALF_M4 = 6'h01;
    localparam logic [5:0] HALF_M16 = 6'h07;
    localparam logic [5:0] HALF_M64 = 6'h1f;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [7:0] CON_RESET = 8'h00;
    localparam logic [1:0] STAT_RESET = 2'h0;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    localparam int CON_WRITE_COLLISION_FLAG = 7;
    localparam int CON_OV = 6;
    localparam int CON_EN = 5;
    localparam int CON_CKP = 4;
    localparam int STAT_SMP = 7;
    localparam int STAT_CKE = 6;
    localparam int PIN_SDO_IN = 0;

    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} ssp_state_t;

    typedef struct packed {
        logic sck;
        logic sdo;
        logic sdo_oe;
        logic sck_oe;
    } ssp_pins_t;

    typedef struct packed {
        ssp_state_t st;
        logic [7:0] buf_r;
        logic [7:0] sr;
        logic [2:0] cnt;
        logic [5:0] div;
        logic [7:0] con;
        logic [1:0] stat;
        logic bf;
        logic flag;
        logic sdo_in;
        logic [1:0] sck_s;
        logic [1:0] sdi_s;
        logic [1:0] ss_s;
        logic [1:0] t2_s;
        logic sck_p;
        logic t2_p;
        logic samp;
        ssp_pins_t pin;
        logic [31:0] rdata;
        logic rvalid;
    } ssp_regs_t;
endpackage

// ==== verification/ssp_port_checker.sv ====
// Assertions on the serial port pins and register bus
// Assumes one clock domain; bound into every port instance
`timescale 1ns/100ps
module ssp_port_checker (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic sleep_in,
    input wire logic irq_en_in,
    input wire logic timer_two_in,
    input wire logic sck_in,
    input wire logic sdi_in,
    input wire logic ss_b_in,
    input wire logic sck_out,
    input wire logic sck_oe_out,
    input wire logic sdo_out,
    input wire logic sdo_oe_out,
    input wire logic port_interrupt_flag_out,
    input wire logic wake_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    sequence s_req;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_ans;
        !avs_waitrequest_out;
    endsequence
    property p_one_wait; s_req |=> s_ans; endproperty
    a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
    property p_wake; wake_out == (port_interrupt_flag_out && irq_en_in); endproperty
    a_wake: assert property (p_wake) else $error("wake mismatch");
    property p_rst;
        $rose(rst_b_in) |-> !(sck_oe_out || sdo_oe_out || port_interrupt_flag_out);
    endproperty
    a_rst: assert property (p_rst) else $error("pins active after reset");
    property p_rate; sck_oe_out && $changed(sck_out) |=> $stable(sck_out); endproperty
    a_rate: assert property (p_rate) else $error("clock half too short");
    property p_sleep; sleep_in && $past(sleep_in) && sck_oe_out |-> $stable(sck_out); endproperty
    a_sleep: assert property (p_sleep) else $error("clock moved in sleep");
    property p_sdo; sck_oe_out && $rose(sck_out) |-> $stable(sdo_out); endproperty
    a_sdo: assert property (p_sdo) else $error("data moved at sample edge");
    property p_sticky;
        port_interrupt_flag_out && !(avs_write_in && avs_address_in == ssp_pkg::ADDR_PIN)
            |=> port_interrupt_flag_out;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");
    property p_hold; !avs_read_in |=> $stable(avs_readdata_out); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind ssp_port ssp_port_checker chk (.*);

// ==== verification/ssp_peer.sv ====
// Far end for master transfers: clock idle low, sample on rise
// Assumes the first bit is wanted before the first rising edge
`timescale 1ns/100ps
module ssp_peer (
    input wire logic rst_b_in,
    input wire logic sck_in,
    input wire logic sdo_in,
    input wire logic [7:0] tx_in,
    output logic sdi_out,
    output logic [7:0] rx_out
);
    logic [2:0] idx;
    initial rx_out = 8'h00;
    assign sdi_out = tx_in[3'h7 - idx];
    always @(posedge sck_in) rx_out <= {rx_out[6:0], sdo_in};
    // Reset keeps a stray edge at power-up from skewing the bit index
    always @(negedge sck_in or negedge rst_b_in) begin
        if (!rst_b_in) idx <= 3'h0;
        else idx <= idx + 3'h1;
    end
endmodule

// ==== verification/spi_master_slave_port_bench.sv ====
// Self-checking bench: master rates, collision, sleep, slave select, overflow
// Assumes the peer model beside it and the bound checker
`timescale 1ns/100ps
module spi_master_slave_port_bench;
    localparam logic [3:0] A_BUF = ssp_pkg::ADDR_BUF;
    localparam logic [3:0] A_CON = ssp_pkg::ADDR_CON;
    localparam logic [3:0] A_ST = ssp_pkg::ADDR_STAT;
    logic clk_in = 1'h0, rst_b_in = 1'h0, avs_read_in = 1'h0, avs_write_in = 1'h0;
    logic [3:0] avs_address_in = 4'h0, avs_byteenable_in = 4'hf;
    logic [31:0] avs_writedata_in = 32'h0000_0000, avs_readdata_out, exp_q[$];
    logic sleep_in = 1'h0, irq_en_in = 1'h0, timer_two_in = 1'h0, ss_b_in = 1'h1;
    logic bsck = 1'h0, bsdi = 1'h0, slv = 1'h0, peer_sdi;
    logic avs_waitrequest_out, sck_out, sck_oe_out, sdo_out, sdo_oe_out;
    logic port_interrupt_flag_out, wake_out;
    logic [7:0] ptx = 8'h00, prx;
    int bad_count = 0, cmp_count = 0, tcnt = 0;
    wire logic sck_in = sck_oe_out ? sck_out : bsck;
    wire logic sdi_in = slv ? bsdi : peer_sdi;
    ssp_port dut (.*);
    // Released data line floats to its pull-up level
    ssp_peer peer (.rst_b_in(rst_b_in), .sck_in(sck_in), .sdo_in(sdo_oe_out ? sdo_out : 1'h1),
        .tx_in(ptx),
        .sdi_out(peer_sdi), .rx_out(prx));
    always #10 clk_in = ~clk_in;
    // Timer input toggles every 5 cycles: one rise per 10
    always @(posedge clk_in) begin
        tcnt <= (tcnt == 4) ? 0 : tcnt + 1;
        if (tcnt == 4) timer_two_in <= ~timer_two_in;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("mismatches %0d compares %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task wr(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        avs_read_in <= !w;
        avs_write_in <= w;
        avs_address_in <= a;
        avs_writedata_in <= d;
        do @(posedge clk_in); while (avs_waitrequest_out !== 1'h0);
        avs_read_in <= 1'h0;
        avs_write_in <= 1'h0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wr(1'h0, a, 32'h0000_0000);
    endtask
    always @(posedge clk_in) begin
        if (avs_read_in && avs_waitrequest_out === 1'h0) check(avs_readdata_out, exp_q.pop_front());
    end
    task sxfer(input logic [7:0] d, input int n, output logic [7:0] g);
        g = 8'h00;
        repeat (8) @(posedge clk_in);
        for (int i = 0; i < n; i++) begin
            bsdi <= d[7 - i];
            repeat (3) @(posedge clk_in);
            @(negedge clk_in) g[7 - i] = sdo_out;
            @(posedge clk_in) bsck <= 1'h1;
            repeat (4) @(posedge clk_in);
            bsck <= 1'h0;
        end
        bsdi <= ~bsdi;
    endtask
    task half_of(output int n);
        logic l;
        l = sck_out;
        while (sck_out === l) @(posedge clk_in);
        l = sck_out;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (sck_out === l);
    endtask
    initial begin
        int n;
        int half[4] = '{2, 8, 32, 10};
        logic [7:0] tx, a, g;
        void'($urandom(32'h6d6fd7f5));
        repeat (6) @(posedge clk_in);
        rst_b_in <= 1'h1;
        rd(A_CON, 32'h0000_0000);
        rd(A_ST, 32'h0000_0000);
        rd(4'h2, ssp_pkg::RD_ZERO);
        wr(1'h1, A_ST, 32'h0000_0040);
        for (int m = 0; m < 4; m++) begin
            irq_en_in <= 1'($urandom);
            wr(1'h1, A_CON, 32'h0000_0000);
            wr(1'h1, A_ST, m == 0 ? 32'h0000_00c0 : 32'h0000_0040);
            wr(1'h1, ssp_pkg::ADDR_PIN, 32'(m == 1));
            wr(1'h1, A_CON, 32'h0000_0020 | m);
            tx = 8'($urandom);
            ptx <= 8'($urandom);
            wr(1'h1, A_BUF, 32'(tx));
            if (m == 0) wr(1'h1, A_BUF, 32'(~tx));
            half_of(n);
            check(32'(n), 32'(half[m]));
            check(32'(sdo_oe_out), 32'(m != 1));
            sleep_in <= (m == 2);
            repeat (40) @(posedge clk_in);
            sleep_in <= 1'h0;
            while (port_interrupt_flag_out !== 1'h1) @(posedge clk_in);
            repeat (70) @(posedge clk_in);
            check(32'(prx), m == 1 ? 32'h0000_00ff : 32'(tx));
            rd(A_ST, m == 0 ? 32'h0000_00c1 : 32'h0000_0041);
            rd(A_BUF, 32'(ptx));
            rd(A_ST, m == 0 ? 32'h0000_00c0 : 32'h0000_0040);
            rd(A_CON, (m == 0 ? 32'h0000_00a0 : 32'h0000_0020) | m);
            wr(1'h1, ssp_pkg::ADDR_PIN, 32'h0000_0000);
        end
        wr(1'h1, A_CON, 32'h0000_0000);
        wr(1'h1, A_CON, 32'h0000_0024);
        slv <= 1'h1;
        tx = 8'($urandom);
        wr(1'h1, A_BUF, 32'(tx));
        ss_b_in <= 1'h0;
        a = 8'($urandom);
        sxfer(a, 8, g);
        check(32'(g), 32'(tx));
        repeat (8) @(posedge clk_in);
        rd(A_BUF, 32'(a));
        sxfer(8'h5a, 3, g);
        ss_b_in <= 1'h1;
        repeat (6) @(posedge clk_in);
        check(32'(sdo_oe_out), 32'h0000_0000);
        ss_b_in <= 1'h0;
        a = 8'($urandom);
        sxfer(a, 8, g);
        repeat (8) @(posedge clk_in);
        rd(A_BUF, 32'(a));
        sxfer(8'h3c, 8, g);
        sxfer(8'hc3, 8, g);
        repeat (8) @(posedge clk_in);
        rd(A_CON, 32'h0000_0064);
        rd(A_BUF, 32'h0000_003c);
        ss_b_in <= 1'h1;
        slv <= 1'h0;
        wr(1'h1, A_CON, 32'h0000_0000);
        wr(1'h1, A_CON, 32'h0000_0020);
        wr(1'h1, A_BUF, 32'h0000_00ff);
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'h0;
        repeat (2) @(posedge clk_in);
        check(32'(sck_oe_out), 32'h0000_0000);
        rst_b_in <= 1'h1;
        rd(A_CON, 32'h0000_0000);
        @(posedge clk_in);
        report_and_stop();
    end
    // Full run is under 2000 cycles; the limit leaves ample margin
    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        report_and_stop();
    end
endmodule
